// file: logic/mdc_pkg.sv
// Constants and carrier types shared by the multichannel DMA controller.
package mdc_pkg;

  // Channel, parameter set and queue sizes.
  localparam int NUM_EVT   = 64;
  localparam int NUM_QCH   = 8;
  localparam int NUM_CH    = 72;
  localparam int NUM_SET   = 256;
  localparam int SET_WORDS = 8;
  localparam int NUM_Q     = 4;
  localparam int Q_DEPTH   = 16;
  localparam int BEAT_B    = 8;

  // Register byte addresses on the APB.
  localparam logic [14:0] A_ER_LO  = 15'h0000;
  localparam logic [14:0] A_ER_HI  = 15'h0004;
  localparam logic [14:0] A_ESR_LO = 15'h0008;
  localparam logic [14:0] A_ESR_HI = 15'h000c;
  localparam logic [14:0] A_ECR_LO = 15'h0010;
  localparam logic [14:0] A_ECR_HI = 15'h0014;
  localparam logic [14:0] A_EER_LO = 15'h0018;
  localparam logic [14:0] A_EER_HI = 15'h001c;
  localparam logic [14:0] A_QER    = 15'h0020;
  localparam logic [14:0] A_QPEND  = 15'h0024;
  localparam logic [14:0] A_IPR_LO = 15'h0028;
  localparam logic [14:0] A_IPR_HI = 15'h002c;
  localparam logic [14:0] A_QIPR   = 15'h0030;
  localparam logic [14:0] A_IEN    = 15'h0034;
  localparam logic [14:0] A_QPRI   = 15'h0038;
  localparam logic [14:0] A_STAT   = 15'h003c;
  localparam logic [14:0] A_ERR    = 15'h0040;
  localparam logic [14:0] A_QMAP   = 15'h0080;

  // Option word fields of a parameter set.
  localparam int O_SFIX = 0;
  localparam int O_DFIX = 1;
  localparam int O_AB   = 2;
  localparam int O_QLO  = 4;
  localparam int O_CHN  = 8;
  localparam int O_CCLO = 9;
  localparam int O_ICHN = 16;
  localparam int O_IEN  = 17;
  localparam logic [15:0] LINK_NULL = 16'hffff;
  localparam logic [11:0] QPRI_RST  = 12'h000;

  // One transfer request as queued for a transfer controller.
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] acnt;
    logic [15:0] bcnt;
    logic [15:0] sbidx;
    logic [15:0] dbidx;
    logic        sfix;
    logic        dfix;
    logic        cpl;
    logic        chn;
    logic [6:0]  chn_ch;
    logic [6:0]  ch;
  } mdc_tr_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [2:0]  prio;
  } mdc_rdq_s;

  typedef struct packed {
    logic        ack;
    logic [63:0] data;
  } mdc_rdr_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [63:0] data;
    logic [2:0]  prio;
  } mdc_wrq_s;

  typedef struct packed {
    logic        valid;
    logic [10:0] widx;
    logic [31:0] data;
  } mdc_cfgw_s;

  typedef enum logic {CC_IDLE, CC_PROC} mdc_cc_e;
  typedef enum logic [1:0] {TC_IDLE, TC_RD, TC_WR} mdc_tc_e;

endpackage

// file: logic/mdc_top.sv
// Channel controller, event queues and four transfer controllers of the DMA.
`timescale 1ns/1ps
`default_nettype none

module mdc_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [14:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [63:0]             evt_in,
  input  wire mdc_pkg::mdc_cfgw_s      cfg_wr,
  output logic                         cfg_wr_ready,
  output mdc_pkg::mdc_rdq_s [3:0]      rd_req,
  input  wire mdc_pkg::mdc_rdr_s [3:0] rd_rsp,
  output mdc_pkg::mdc_wrq_s [3:0]      wr_req,
  input  wire logic [3:0]              wr_ack,
  output logic                         irq_done,
  output logic                         irq_err
);
  import mdc_pkg::*;

  typedef struct packed {
    mdc_tc_e     st;
    mdc_tr_s     tr;
    logic [15:0] al;
    logic [15:0] bl;
    logic [31:0] sp;
    logic [31:0] dp;
    logic [31:0] sa;
    logic [31:0] da;
    logic [63:0] db;
  } mdc_tcs_s;

  typedef struct packed {
    logic [63:0]                 ev1;
    logic [63:0]                 ev2;
    logic [63:0]                 ev3;
    logic [63:0]                 er;
    logic [63:0]                 event_enable_register;
    logic [7:0]                  qer;
    logic [7:0]                  qpend;
    logic [NUM_CH-1:0]           ipr;
    logic [1:0]                  ien;
    logic [1:0]                  errf;
    logic [6:0]                  errch;
    logic [11:0]                 qpri;
    logic [7:0][7:0]             qset;
    logic [7:0][2:0]             qtrig;
    mdc_cc_e                     cc;
    logic [6:0]                  cch;
    logic [7:0]                  cset;
    mdc_tr_s [3:0][Q_DEPTH-1:0]  q;
    logic [3:0][3:0]             qhd;
    logic [3:0][3:0]             qtl;
    logic [3:0][4:0]             qcnt;
    mdc_tcs_s [3:0]              tc;
    logic [31:0]                 prdata;
    logic                        was_idle;
  } mdc_st_s;

  mdc_st_s           s;
  mdc_st_s           n;
  logic [31:0]       prm [NUM_SET*SET_WORDS];
  logic [7:0][31:0]  w;
  logic [7:0][31:0]  lw;
  logic [7:0][31:0]  upd;
  logic [7:0][31:0]  set_wd;
  logic              set_we;
  logic              mem_we;
  logic [10:0]       mem_wi;
  logic [31:0]       mem_wd;
  logic              phit;
  logic              acc;
  logic              wr;
  logic              hit;
  logic [31:0]       rdv;
  logic [63:0]       evset;
  logic [63:0]       evclr;
  logic [63:0]       rise;
  logic [7:0]        qtrg;
  logic [7:0]        qclr;
  logic [NUM_CH-1:0] iset;
  logic [NUM_CH-1:0] iclr;
  logic [1:0]        eset;
  logic [1:0]        eclr;
  logic [3:0]        qpush;
  logic [3:0]        qpop;
  logic [1:0]        cq;
  logic              ab;
  logic              fin;
  logic              take;
  logic [15:0]       bcnt;
  logic [15:0]       ccnt;
  logic [71:0]       pend;
  mdc_tr_s           ctr;
  mdc_tr_s           dtr;

  // Lowest set bit wins, so low channel numbers have precedence.
  function automatic logic [6:0] mdc_first(input logic [71:0] v);
    logic [6:0] r;
    r = '0;
    for (int i = 71; i >= 0; i--) begin
      if (v[i]) begin
        r = 7'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] mdc_sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  // Quick channels whose mapped trigger word sits at the written word.
  function automatic logic [7:0] mdc_qhit(input logic [10:0]     wi,
                                          input logic [7:0]      en,
                                          input logic [7:0][7:0] ms,
                                          input logic [7:0][2:0] mt);
    logic [7:0] h;
    h = '0;
    for (int i = 0; i < NUM_QCH; i++) begin
      h[i] = en[i] && (wi == {ms[i], mt[i]});
    end
    return h;
  endfunction

  function automatic logic [31:0] mdc_step(input logic fix);
    return fix ? 32'h0 : 32'(BEAT_B);
  endfunction

  // Parameter set of the channel in service and of its link target.
  always_comb begin
    for (int k = 0; k < SET_WORDS; k++) begin
      w[k] = prm[{s.cset, 3'(k)}];
    end
    for (int k = 0; k < SET_WORDS; k++) begin
      lw[k] = prm[{w[5][7:0], 3'(k)}];
    end
  end

  // Parameter memory; a whole set is rewritten in one cycle after service.
  always_ff @(posedge pclk) begin
    if (set_we) begin
      for (int k = 0; k < SET_WORDS; k++) begin
        prm[{s.cset, 3'(k)}] <= set_wd[k];
      end
    end else if (mem_we) begin
      prm[mem_wi] <= mem_wd;
    end
  end

  // Parameter accesses wait while the channel controller owns the memory.
  assign phit         = (paddr[14:13] == 2'b10);
  assign acc          = psel && penable;
  assign pready       = !phit || s.was_idle;
  assign wr           = acc && pwrite && pready;
  assign pslverr      = acc && !hit;
  assign prdata       = s.prdata;
  assign cfg_wr_ready = (s.cc == CC_IDLE) && !(psel && phit);
  assign irq_done     = s.ien[0] && (|s.ipr);
  assign irq_err      = s.ien[1] && (|s.errf);

  // Transfer controller ports come straight from controller state.
  always_comb begin
    for (int t = 0; t < NUM_Q; t++) begin
      rd_req[t].valid = (s.tc[t].st == TC_RD);
      rd_req[t].addr  = s.tc[t].sp;
      rd_req[t].prio  = s.qpri[t*3 +: 3];
      wr_req[t].valid = (s.tc[t].st == TC_WR);
      wr_req[t].addr  = s.tc[t].dp;
      wr_req[t].data  = s.tc[t].db;
      wr_req[t].prio  = s.qpri[t*3 +: 3];
    end
  end

  // Next-state logic for the whole controller.
  always_comb begin
    n      = s;
    mem_we = 1'b0;
    mem_wi = '0;
    mem_wd = '0;
    set_we = 1'b0;
    set_wd = w;
    hit    = 1'b1;
    rdv    = '0;
    evclr  = '0;
    qtrg   = '0;
    qclr   = '0;
    iset   = '0;
    iclr   = '0;
    eset   = '0;
    eclr   = '0;
    qpush  = '0;
    qpop   = '0;
    take   = 1'b0;
    // Two-flop synchronisers; edges are taken from the settled stages.
    n.ev1  = evt_in;
    n.ev2  = s.ev1;
    n.ev3  = s.ev2;
    rise   = s.ev2 & ~s.ev3;
    evset  = rise;
    if ((rise & s.er) != '0) begin
      eset[0] = 1'b1;
      n.errch = mdc_first({8'h0, rise & s.er});
    end
    n.was_idle = (s.cc == CC_IDLE);

    // Register decode, reads and writes.
    if (phit) begin
      rdv = prm[paddr[12:2]];
      if (wr) begin
        mem_we = 1'b1;
        mem_wi = paddr[12:2];
        mem_wd = pwdata;
        qtrg   = mdc_qhit(paddr[12:2], s.qer, s.qset, s.qtrig);
      end
    end else if (paddr == A_ER_LO) begin
      rdv = s.er[31:0];
    end else if (paddr == A_ER_HI) begin
      rdv = s.er[63:32];
    end else if (paddr == A_ESR_LO) begin
      if (wr) evset[31:0] = evset[31:0] | pwdata;
    end else if (paddr == A_ESR_HI) begin
      if (wr) evset[63:32] = evset[63:32] | pwdata;
    end else if (paddr == A_ECR_LO) begin
      if (wr) evclr[31:0] = pwdata;
    end else if (paddr == A_ECR_HI) begin
      if (wr) evclr[63:32] = pwdata;
    end else if (paddr == A_EER_LO) begin
      rdv = s.event_enable_register[31:0];
      if (wr) n.event_enable_register[31:0] = pwdata;
    end else if (paddr == A_EER_HI) begin
      rdv = s.event_enable_register[63:32];
      if (wr) n.event_enable_register[63:32] = pwdata;
    end else if (paddr == A_QER) begin
      rdv = {24'h0, s.qer};
      if (wr) n.qer = pwdata[7:0];
    end else if (paddr == A_QPEND) begin
      rdv = {24'h0, s.qpend};
    end else if (paddr == A_IPR_LO) begin
      rdv = s.ipr[31:0];
      if (wr) iclr[31:0] = pwdata;
    end else if (paddr == A_IPR_HI) begin
      rdv = s.ipr[63:32];
      if (wr) iclr[63:32] = pwdata;
    end else if (paddr == A_QIPR) begin
      rdv = {24'h0, s.ipr[71:64]};
      if (wr) iclr[71:64] = pwdata[7:0];
    end else if (paddr == A_IEN) begin
      rdv = {30'h0, s.ien};
      if (wr) n.ien = pwdata[1:0];
    end else if (paddr == A_QPRI) begin
      rdv = {20'h0, s.qpri};
      if (wr) n.qpri = pwdata[11:0];
    end else if (paddr == A_STAT) begin
      rdv = {s.qcnt, 3'h0, s.cch, 1'b0, s.cc};
    end else if (paddr == A_ERR) begin
      rdv = {16'h0, 1'b0, s.errch, 6'h0, s.errf};
      if (wr) eclr = pwdata[1:0];
    end else if (paddr[14:5] == A_QMAP[14:5]) begin
      rdv = {21'h0, s.qtrig[paddr[4:2]], s.qset[paddr[4:2]]};
      if (wr) begin
        n.qset[paddr[4:2]]  = pwdata[7:0];
        n.qtrig[paddr[4:2]] = pwdata[10:8];
      end
    end else begin
      hit = 1'b0;
    end
    n.prdata = rdv;

    // Writes arriving through the configuration bus bridge.
    if (cfg_wr.valid && cfg_wr_ready) begin
      mem_we = 1'b1;
      mem_wi = cfg_wr.widx;
      mem_wd = cfg_wr.data;
      qtrg   = mdc_qhit(cfg_wr.widx, s.qer, s.qset, s.qtrig);
    end

    // Work out the request and the updated set for the channel in service.
    ab   = w[0][O_AB];
    bcnt = w[2][31:16];
    ccnt = w[7][15:0];
    cq   = w[0][O_QLO +: 2];
    fin  = ab ? (ccnt <= 16'h1) : ((ccnt <= 16'h1) && (bcnt <= 16'h1));
    upd  = w;
    if (ab || (bcnt <= 16'h1)) begin
      // End of a frame: step by the frame indexes, the third dimension.
      upd[1] = w[1] + mdc_sx(w[6][15:0]);
      upd[3] = w[3] + mdc_sx(w[6][31:16]);
      upd[7] = {16'h0, ccnt - 16'h1};
      if (!ab) begin
        upd[2][31:16] = w[5][31:16];
      end
    end else begin
      upd[1]        = w[1] + mdc_sx(w[4][15:0]);
      upd[3]        = w[3] + mdc_sx(w[4][31:16]);
      upd[2][31:16] = bcnt - 16'h1;
    end
    if (fin) begin
      // An exhausted set with no link is nulled so a stray trigger is caught as an error.
      upd[2] = '0;
      upd[7] = '0;
    end
    ctr.src    = w[1];
    ctr.dst    = w[3];
    ctr.acnt   = w[2][15:0];
    ctr.bcnt   = ab ? bcnt : 16'h1;
    ctr.sbidx  = w[4][15:0];
    ctr.dbidx  = w[4][31:16];
    ctr.sfix   = w[0][O_SFIX];
    ctr.dfix   = w[0][O_DFIX];
    ctr.cpl    = fin && w[0][O_IEN];
    ctr.chn    = fin ? w[0][O_CHN] : w[0][O_ICHN];
    ctr.chn_ch = w[0][O_CCLO +: 7];
    ctr.ch     = s.cch;

    // Only enabled events and armed quick channels are eligible.
    pend = {s.qpend, s.er & s.event_enable_register};
    case (s.cc)
      CC_IDLE: begin
        if (!(psel && phit) && (pend != '0)) begin
          n.cch = mdc_first(pend);
          if (n.cch[6]) begin
            n.cset = s.qset[n.cch[2:0]];
          end else begin
            n.cset = {2'b00, n.cch[5:0]};
          end
          n.cc = CC_PROC;
        end
      end
      CC_PROC: begin
        if (w[2][15:0] == 16'h0) begin
          eset[1] = 1'b1;
          n.errch = s.cch;
          take    = 1'b1;
        end else if (s.qcnt[cq] != 5'(Q_DEPTH)) begin
          qpush[cq] = 1'b1;
          take      = 1'b1;
          set_we    = 1'b1;
          if (fin && (w[5][15:0] != LINK_NULL)) begin
            set_wd = lw;
          end else begin
            set_wd = upd;
          end
        end
        if (take) begin
          n.cc = CC_IDLE;
          if (s.cch[6]) begin
            qclr[s.cch[2:0]] = 1'b1;
          end else begin
            evclr[s.cch[5:0]] = 1'b1;
          end
        end
      end
      default: n.cc = CC_IDLE;
    endcase

    // Transfer controllers: one request at a time, well inside four in flight.
    for (int t = 0; t < NUM_Q; t++) begin
      dtr = s.tc[t].tr;
      case (s.tc[t].st)
        TC_IDLE: begin
          if (s.qcnt[t] != 5'h0) begin
            qpop[t] = 1'b1;
            dtr     = s.q[t][s.qhd[t]];
            n.tc[t].tr = dtr;
            n.tc[t].al = dtr.acnt;
            n.tc[t].bl = dtr.bcnt;
            n.tc[t].sp = dtr.src;
            n.tc[t].sa = dtr.src;
            n.tc[t].dp = dtr.dst;
            n.tc[t].da = dtr.dst;
            n.tc[t].st = TC_RD;
          end
        end
        TC_RD: begin
          if (rd_rsp[t].ack) begin
            n.tc[t].db = rd_rsp[t].data;
            n.tc[t].st = TC_WR;
          end
        end
        TC_WR: begin
          if (wr_ack[t]) begin
            n.tc[t].st = TC_RD;
            if (s.tc[t].al > 16'(BEAT_B)) begin
              n.tc[t].al = s.tc[t].al - 16'(BEAT_B);
              n.tc[t].sp = s.tc[t].sp + mdc_step(dtr.sfix);
              n.tc[t].dp = s.tc[t].dp + mdc_step(dtr.dfix);
            end else if (s.tc[t].bl > 16'h1) begin
              // Next array of the frame, the second dimension.
              n.tc[t].al = dtr.acnt;
              n.tc[t].bl = s.tc[t].bl - 16'h1;
              n.tc[t].sa = s.tc[t].sa + mdc_sx(dtr.sbidx);
              n.tc[t].da = s.tc[t].da + mdc_sx(dtr.dbidx);
              n.tc[t].sp = n.tc[t].sa;
              n.tc[t].dp = n.tc[t].da;
            end else begin
              n.tc[t].st = TC_IDLE;
              if (dtr.cpl) begin
                iset[dtr.ch] = 1'b1;
              end
              if (dtr.chn && !dtr.chn_ch[6]) begin
                evset[dtr.chn_ch[5:0]] = 1'b1;
              end
            end
          end
        end
        default: n.tc[t].st = TC_IDLE;
      endcase
    end

    // Event queues are plain ring buffers, so order is kept.
    for (int q = 0; q < NUM_Q; q++) begin
      if (qpush[q]) begin
        n.q[q][s.qtl[q]] = ctr;
        n.qtl[q] = s.qtl[q] + 4'h1;
      end
      if (qpop[q]) begin
        n.qhd[q] = s.qhd[q] + 4'h1;
      end
      n.qcnt[q] = s.qcnt[q] + {4'h0, qpush[q]} - {4'h0, qpop[q]};
    end

    // Sticky flags: a set in the same cycle as its clear wins.
    n.er    = (s.er & ~evclr) | evset;
    n.qpend = (s.qpend & ~qclr) | qtrg;
    n.ipr   = (s.ipr & ~iclr) | iset;
    n.errf  = (s.errf & ~eclr) | eset;
  end

  // All controller state in one register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s      <= '0;
      s.qpri <= QPRI_RST;
    end else begin
      s <= n;
    end
  end

endmodule

`default_nettype wire

// file: dv/mdc_asserts.sv
// Port checker for the DMA controller: register bus and transfer controller zero.
`timescale 1ns/1ps
`default_nettype none
module mdc_asserts (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic [14:0]             paddr,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire mdc_pkg::mdc_rdq_s [3:0] rd_req,
  input wire mdc_pkg::mdc_rdr_s [3:0] rd_rsp,
  input wire mdc_pkg::mdc_wrq_s [3:0] wr_req,
  input wire logic [3:0]              wr_ack
);
  import mdc_pkg::*;
  logic [63:0] rd_data_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Last beat read, so that the write beat can be tied to what was read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_r <= '0;
    end else if (rd_req[0].valid && rd_rsp[0].ack) begin
      rd_data_r <= rd_rsp[0].data;
    end
  end
  a_reg_no_wait: assert property (
    psel && penable && paddr < 15'h4000 |-> pready) else $error("register access waited");
  a_slverr_hole: assert property (
    psel && penable && paddr == 15'h0044 |-> pslverr && pready) else $error("hole not refused");
  a_slverr_reg: assert property (
    psel && penable && paddr == A_ESR_LO |-> !pslverr) else $error("mapped access refused");
  a_rd_hold: assert property (
    rd_req[0].valid && !rd_rsp[0].ack |=> rd_req[0].valid && $stable(rd_req[0].addr))
    else $error("read request dropped early");
  a_rd_then_wr: assert property (
    rd_req[0].valid && rd_rsp[0].ack |=> !rd_req[0].valid ##0 wr_req[0].valid)
    else $error("write beat did not follow read");
  a_wr_hold: assert property (
    wr_req[0].valid && !wr_ack[0] |=> wr_req[0].valid && $stable(wr_req[0].data))
    else $error("write request dropped early");
  a_wr_data: assert property (
    wr_req[0].valid |-> wr_req[0].data == rd_data_r) else $error("write data not read data");
  a_one_port: assert property (
    !(rd_req[0].valid && wr_req[0].valid)) else $error("read and write at once");
endmodule
`default_nettype wire

// file: dv/mdc_mem_model.sv
// Memory model answering the read and write ports of the four transfer controllers.
`timescale 1ns/1ps
`default_nettype none
module mdc_mem_model (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    slow,
  input  wire mdc_pkg::mdc_rdq_s [3:0] rd_req,
  output mdc_pkg::mdc_rdr_s [3:0]      rd_rsp,
  input  wire mdc_pkg::mdc_wrq_s [3:0] wr_req,
  output logic [3:0]                   wr_ack
);
  import mdc_pkg::*;
  int wait_c [4];
  // Acks at once or after three cycles; idle data toggles so stale data never looks valid.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_rsp <= '0;
      wr_ack <= '0;
      for (int t = 0; t < 4; t++) wait_c[t] <= 0;
    end else begin
      for (int t = 0; t < 4; t++) begin
        rd_rsp[t].ack <= 1'b0;
        rd_rsp[t].data <= ~rd_rsp[t].data;
        wr_ack[t] <= 1'b0;
        if ((rd_req[t].valid || wr_req[t].valid) && !rd_rsp[t].ack && !wr_ack[t]) begin
          if (wait_c[t] < (slow ? 3 : 0)) begin
            wait_c[t] <= wait_c[t] + 1;
          end else begin
            wait_c[t] <= 0;
            rd_rsp[t].ack <= rd_req[t].valid;
            rd_rsp[t].data <= {rd_req[t].addr ^ 32'h5a5a5a5a, rd_req[t].addr};
            wr_ack[t] <= !rd_req[t].valid;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/multichannel_dma_controller_test.sv
// Self-checking bench for the multichannel DMA controller.
`timescale 1ns/1ps
`default_nettype none
module multichannel_dma_controller_test;
  import mdc_pkg::*;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err_r;
  logic           irq_done, irq_err, cfg_wr_ready;
  logic [14:0]    paddr;
  logic [31:0]    pwdata, prdata, rdat, lfsr_r;
  logic [63:0]    evt_in;
  logic [3:0]     wr_ack;
  mdc_cfgw_s      cfg_wr;
  mdc_rdq_s [3:0] rd_req;
  mdc_rdr_s [3:0] rd_rsp;
  mdc_wrq_s [3:0] wr_req;
  logic [95:0]    exp_q [$];
  int             bad_count, n_compared;

  mdc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt_in(evt_in), .cfg_wr(cfg_wr), .cfg_wr_ready(cfg_wr_ready),
    .rd_req(rd_req), .rd_rsp(rd_rsp), .wr_req(wr_req), .wr_ack(wr_ack),
    .irq_done(irq_done), .irq_err(irq_err));
  mdc_mem_model u_mem (.pclk(pclk), .presetn(presetn), .slow(slow), .rd_req(rd_req),
    .rd_rsp(rd_rsp), .wr_req(wr_req), .wr_ack(wr_ack));

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic test_done;
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Contents the memory model returns for an address.
  function automatic logic [63:0] mem(input logic [31:0] a);
    return {a ^ 32'h5a5a5a5a, a};
  endfunction

  // One APB transfer; an idle cycle first keeps the strobes from toggling twice in a step.
  task automatic apb(input logic w, input logic [14:0] a, input logic [31:0] d);
    int n;
    logic ok;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Ready is sampled mid-cycle, where it is settled, so the taking edge is the one that follows.
    do begin
      @(negedge pclk);
      ok = (pready === 1'b1);
      err_r = pslverr;
      @(posedge pclk);
      n++;
    end while (!ok && n < 300);
    if (!ok) bad_count++;
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [14:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(96'(rdat), 96'(e));
  endtask

  // Parameter set: two arrays of 16 bytes, one frame, no link; trigger word by bridge if asked.
  task automatic set_up(input int n, input logic [31:0] opt, src, dst, input logic brg);
    logic [31:0] w [8];
    logic        ok;
    w = '{opt, src, 32'h0002_0010, dst, 32'h0080_0040, 32'h0002_ffff, 32'h0, 32'h1};
    for (int i = 0; i < 7; i++) apb(1'b1, 15'(16'h4000 + n * 32 + i * 4), w[i]);
    if (brg) begin
      @(posedge pclk);
      cfg_wr <= '{1'b1, 11'(n * 8 + 7), w[7]};
      // The bridge write is taken at the edge where ready was high before it.
      do begin
        @(negedge pclk);
        ok = (cfg_wr_ready === 1'b1);
        @(posedge pclk);
      end while (!ok);
      cfg_wr.valid <= 1'b0;
    end else apb(1'b1, 15'(16'h4000 + n * 32 + 28), w[7]);
  endtask

  task automatic expect_arr(input logic [31:0] src, dst, input int b0, nb);
    for (int b = b0; b < b0 + nb; b++)
      for (int k = 0; k < 2; k++)
        exp_q.push_back({dst + 32'(b * 128 + k * 8), mem(src + 32'(b * 64 + k * 8))});
  endtask

  task automatic settle;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(96'(exp_q.size()), 96'h0);
    repeat (30) @(posedge pclk);
  endtask

  // Every accepted write beat must be the next one the model expects.
  always @(posedge pclk) begin
    for (int t = 0; t < 4; t++)
      if (presetn && wr_req[t].valid && wr_ack[t]) begin
        if (exp_q.size() == 0) chk(96'h0, 96'h1);
        else chk({wr_req[t].addr, wr_req[t].data}, exp_q.pop_front());
      end
  end

  // Main sequence.
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, slow} = 4'h0;
    paddr = '0;
    pwdata = '0;
    evt_in = '0;
    cfg_wr = '0;
    bad_count = 0;
    n_compared = 0;
    lfsr_r = 32'h00015a3e;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_EER_LO, 32'h0);
    rd(15'h0044, 32'h0);
    chk({95'h0, err_r}, 96'h1);
    lfsr_r = lfsr(lfsr_r);
    apb(1'b1, A_QPRI, lfsr_r);
    rd(A_QPRI, {20'h0, lfsr_r[11:0]});
    apb(1'b1, A_IEN, 32'h3);
    // Event on a disabled channel is held, then serviced one array at a time.
    lfsr_r = lfsr(lfsr_r);
    set_up(3, 32'h0, {lfsr_r[31:3], 3'h0}, 32'h0010_0000, 1'b0);
    evt_in <= 64'h8;
    repeat (4) @(posedge pclk);
    evt_in <= '0;
    repeat (10) @(posedge pclk);
    rd(A_ER_LO, 32'h8);
    expect_arr({lfsr_r[31:3], 3'h0}, 32'h0010_0000, 0, 1);
    apb(1'b1, A_EER_LO, 32'h68);
    settle();
    rd(A_ER_LO, 32'h0);
    expect_arr({lfsr_r[31:3], 3'h0}, 32'h0010_0000, 1, 1);
    apb(1'b1, A_ESR_LO, 32'h8);
    settle();
    apb(1'b1, A_ESR_LO, 32'h8);
    repeat (20) @(posedge pclk);
    rd(A_ERR, 32'h0302);
    @(negedge pclk);
    chk({95'h0, irq_err}, 96'h1);
    // Frame transfer whose completion chains to channel 6.
    set_up(5, 32'h0002_0d04, 32'h0200_0000, 32'h0300_0000, 1'b0);
    set_up(6, 32'h0, 32'h0400_0000, 32'h0500_0000, 1'b0);
    expect_arr(32'h0200_0000, 32'h0300_0000, 0, 2);
    expect_arr(32'h0400_0000, 32'h0500_0000, 0, 1);
    apb(1'b1, A_ESR_LO, 32'h20);
    settle();
    rd(A_IPR_LO, 32'h20);
    @(negedge pclk);
    chk({95'h0, irq_done}, 96'h1);
    apb(1'b1, A_IPR_LO, 32'h20);
    @(negedge pclk);
    chk({95'h0, irq_done}, 96'h0);
    // Quick channel on set 20, trigger word written over the bridge, slow memory.
    slow <= 1'b1;
    apb(1'b1, A_QMAP, 32'h0714);
    apb(1'b1, A_QER, 32'h1);
    expect_arr(32'h0600_0000, 32'h0700_0000, 0, 2);
    set_up(20, 32'h14, 32'h0600_0000, 32'h0700_0000, 1'b1);
    settle();
    test_done();
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    test_done();
  end
endmodule

bind mdc_top mdc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .rd_req(rd_req), .rd_rsp(rd_rsp), .wr_req(wr_req), .wr_ack(wr_ack));
`default_nettype wire
